// >>> bench/nvm_access_asserts.sv
// nvm_access_asserts.sv: port-level properties of the nvm access controller
// assumes bind onto nvm_access; one clock, synchronous active-high reset
`timescale 1ns/10ps
`include "nvm_access_defines.vh"
module nvm_access_asserts #(
  parameter FLASH_PROG_CYCLES = 20
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // wishbone side
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  // cpu side
  input wire o_cpu_stall,
  input wire o_write_done_flag
);
  wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  reg [31:0] stall_len_q;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // cycles the stall has already been high in a row
  always @(posedge i_clk) begin
    if (i_rst || !o_cpu_stall) begin
      stall_len_q <= 32'h0;
    end else begin
      stall_len_q <= stall_len_q + 32'h1;
    end
  end
  a_ack_after_take: assert property (take |=> o_wb_ack)
    else $error("ack missing after a request");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_idle_data_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero outside ack");
  a_unlock_reads_zero: assert property (take && !i_wb_we && i_wb_adr == `OFS_UNLOCK |=> o_wb_dat == 32'h0)
    else $error("unlock register read not zero");
  a_reset_quiet: assert property (disable iff (1'b0) i_rst |=> !o_cpu_stall && !o_write_done_flag)
    else $error("stall or done after reset");
  a_done_sticky: assert property (o_write_done_flag && !(take && i_wb_we && i_wb_adr == `OFS_STATUS) |=> o_write_done_flag)
    else $error("done flag dropped without a clear");
  a_stall_min_two: assert property ($rose(o_cpu_stall) |-> o_cpu_stall [*2])
    else $error("stall shorter than two cycles");
  a_stall_bounded: assert property (o_cpu_stall |-> stall_len_q < FLASH_PROG_CYCLES + 2)
    else $error("stall longer than program time");
endmodule
bind nvm_access nvm_access_asserts #(.FLASH_PROG_CYCLES(FLASH_PROG_CYCLES)) nvm_access_asserts_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_cpu_stall(o_cpu_stall),
  .o_write_done_flag(o_write_done_flag));

// >>> bench/test_nvm_access.sv
// test_nvm_access.sv: register-level bench for the nvm access controller
// assumes short program and write counts so each wait stays brief
`timescale 1ns/10ps
`include "nvm_access_defines.vh"
module test_nvm_access;
  localparam PROG = 20;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic abort_rst = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] o_wb_dat;
  logic [31:0] rd;
  logic o_wb_ack;
  logic o_cpu_stall;
  logic o_write_done_flag;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  int n = 0;
  nvm_access #(.FLASH_PROG_CYCLES(PROG), .EE_WRITE_CYCLES(20)) nvm_access_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_abort_rst(abort_rst), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_cpu_stall(o_cpu_stall), .o_write_done_flag(o_write_done_flag));
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; n restarts with the stall seen in the ack cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge i_clk);
    while (o_wb_ack !== 1'b1) @(posedge i_clk);
    rd = o_wb_dat;
    n = (o_cpu_stall === 1'b1) ? 1 : 0;
    req <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask
  task automatic start(input logic [7:0] c);
    wb(1'b1, `OFS_UNLOCK, {24'h0, `UNLOCK_FIRST});
    wb(1'b1, `OFS_UNLOCK, {24'h0, `UNLOCK_SECOND});
    wb(1'b1, `OFS_CONTROL, {24'h0, c});
  endtask
  // counts stall cycles over a fixed window
  task automatic watch();
    repeat (40) begin
      @(negedge i_clk);
      if (o_cpu_stall === 1'b1) n++;
    end
  endtask
  task automatic load(input logic [7:0] a);
    wb(1'b1, `OFS_ADDR_HIGH, 32'h0);
    wb(1'b1, `OFS_ADDR_LOW, {24'h0, a});
    wb(1'b1, `OFS_DATA_LOW, {24'h0, a + 8'h20});
    wb(1'b1, `OFS_DATA_HIGH, {24'h0, a});
  endtask
  task automatic ignored();
    watch();
    chk("ignored stall", 32'h0, n);
    chk("ignored done", 32'h0, {31'h0, o_write_done_flag});
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rdchk("control", `OFS_CONTROL, 32'hFF, {24'h0, `CONTROL_RST});
    rdchk("protect", `OFS_PROTECT, 32'h3, {30'h0, `PROTECT_RST});
    rdchk("unlock", `OFS_UNLOCK, 32'hFFFFFFFF, 32'h0);
    rdchk("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, `OFS_ADDR_LOW, 32'h05);
    wb(1'b1, `OFS_DATA_LOW, 32'hA5);
    start(8'h02);
    rdchk("no enable", `OFS_CONTROL, 32'h2, 32'h0);
    wb(1'b1, `OFS_CONTROL, 32'h06);
    rdchk("no unlock", `OFS_CONTROL, 32'h2, 32'h0);
    wb(1'b1, `OFS_UNLOCK, 32'h55);
    wb(1'b1, `OFS_ADDR_LOW, 32'h05);
    wb(1'b1, `OFS_UNLOCK, 32'hAA);
    wb(1'b1, `OFS_CONTROL, 32'h06);
    rdchk("split unlock", `OFS_CONTROL, 32'h2, 32'h0);
    start(8'h06);
    wb(1'b1, `OFS_CONTROL, 32'h00);
    rdchk("start held", `OFS_CONTROL, 32'h2, 32'h2);
    while (o_write_done_flag !== 1'b1) @(negedge i_clk);
    watch();
    rdchk("start cleared", `OFS_CONTROL, 32'h6, 32'h0);
    chk("done sticky", 32'h1, {31'h0, o_write_done_flag});
    wb(1'b1, `OFS_STATUS, 32'h0);
    chk("done clear", 32'h0, {31'h0, o_write_done_flag});
    wb(1'b1, `OFS_DATA_LOW, 32'h00);
    wb(1'b1, `OFS_CONTROL, 32'h01);
    rdchk("eeprom byte", `OFS_DATA_LOW, 32'hFF, 32'hA5);
    wb(1'b1, `OFS_CONTROL, 32'h84);
    for (int i = 0; i < 4; i++) begin
      load(8'h10 + i[7:0]);
      start(8'h86);
      watch();
      chk("stall", (i == 3) ? PROG + 2 : 2, n);
      chk("word done", 32'h1, {31'h0, o_write_done_flag});
      wb(1'b1, `OFS_STATUS, 32'h0);
    end
    wb(1'b1, `OFS_ADDR_LOW, 32'h11);
    wb(1'b1, `OFS_CONTROL, 32'h81);
    watch();
    chk("read stall", 32'h2, n);
    rdchk("flash low", `OFS_DATA_LOW, 32'hFF, 32'h31);
    rdchk("flash high", `OFS_DATA_HIGH, 32'h3F, 32'h11);
    wb(1'b1, `OFS_CONTROL, 32'h84);
    load(8'h12);
    start(8'h86);
    ignored();
    load(8'h18);
    start(8'h86);
    watch();
    chk("next block word", 32'h2, n);
    wb(1'b1, `OFS_STATUS, 32'h0);
    load(8'h1D);
    start(8'h86);
    ignored();
    for (int p = 0; p < 3; p++) begin
      wb(1'b1, `OFS_PROTECT, p);
      load(8'h19);
      start(8'h86);
      ignored();
    end
    wb(1'b1, `OFS_CONTROL, 32'h04);
    start(8'h06);
    @(posedge i_clk);
    i_rst <= 1'b1;
    abort_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    abort_rst <= 1'b0;
    rdchk("abort flag", `OFS_CONTROL, 32'hFF, 32'h08);
    rdchk("abort addr", `OFS_ADDR_LOW, 32'hFF, 32'h19);
    rdchk("abort data", `OFS_DATA_LOW, 32'hFF, 32'h39);
    finish_test();
  end
endmodule

// >>> hw/nvm_access.v
// nvm_access.v: data eeprom and program flash self-access controller
// assumes a classic wishbone master, an instruction-clock cpu that honours
// o_cpu_stall, and eeprom/flash arrays held as flip-flop storage
//
// Summary of operation
// [R1] eeprom read: address set, select clear, read bit puts byte in data next cycle
// [R2] data registers hold fetched value until next read or software write
// [R3] write starts only after 55h then AAh to unlock then start bit
// [R4] write start bit cannot set unless write enable already set
// [R5] write enable never cleared by hardware; clearing it spares running write
// [R6] write completion clears start bit and sets sticky done flag
// [R7] software should disable interrupts around the unlock sequence
// [R8] software checks start bit or done flag before next data write
// [R9] flash read stalls cpu for two cycles while fetching
// [R10] fetched flash word lands in low and high data registers
// [R11] flash write allowed only outside protected segment
// [R12] flash written in four-word aligned blocks, never spanning a boundary
// [R13] words loaded in order 00,01,10,11 into block buffer
// [R14] last word erases block then programs buffer into it
// [R15] software fills all four buffer words, reading back unchanged ones
// [R16] two setup cycles follow the start bit before erase and program
// [R17] first three loads immediate; last word stalls cpu about 4 ms
// [R18] execution resumes at third instruction after start bit write
// [R19] flash sequence to a disallowed address is ignored
// [R20] software only sets read and start bits; hardware clears them
// [R21] reset during write sets abort flag, address and data kept
// [R22] unlock register has no storage and reads zero
// [R23] unlock sequence needs consecutive register writes; others reset it
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "nvm_access_defines.vh"

module nvm_access #(
  parameter EE_ABITS = 8,
  parameter FL_ABITS = 13,
  parameter FLASH_PROG_CYCLES = `FLASH_PROG_CYC,
  parameter EE_WRITE_CYCLES = `EE_WRITE_CYC
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // abort cause: reset that interrupts a write
  input wire i_abort_rst,
  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // cpu side
  output wire o_cpu_stall,
  output wire o_write_done_flag
);

  // one-hot sequencer states
  localparam ST_IDLE = 5'b00001;
  localparam ST_FREAD = 5'b00010;
  localparam ST_SETUP = 5'b00100;
  localparam ST_PROG = 5'b01000;
  localparam ST_EEWR = 5'b10000;
  // unlock detector states, one-hot
  localparam UL_IDLE = 3'b001;
  localparam UL_GOT55 = 3'b010;
  localparam UL_ARMED = 3'b100;

  reg [7:0] ee_mem [0:(1<<EE_ABITS)-1];
  reg [13:0] fl_mem [0:(1<<FL_ABITS)-1];
  reg [13:0] buf_q [0:3];
  reg [7:0] data_low_q;
  reg [5:0] data_high_q;
  reg [7:0] addr_low_q;
  reg [4:0] addr_high_q;
  reg memory_select_q;
  reg write_enable_q;
  reg write_start_q;
  reg read_start_q;
  reg write_abort_q;
  reg write_done_q;
  reg [1:0] flash_protect_q;
  reg [2:0] unlock_q;
  reg [4:0] state_q;
  // counts down fetch, setup and write cycles
  reg [31:0] cnt_q;
  // order counter: low address bits of the next block word expected
  reg [1:0] blk_q;
  // block address of word 00, so later words cannot leave that block
  reg [10:0] blk_base_q;
  reg in_write_q;
  reg op_flash_q;

  // ack is registered, so a held request is taken once and then masked
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr_acc = wb_req & i_wb_we & i_wb_sel[0];
  wire rd_acc = wb_req & ~i_wb_we;
  wire [7:0] wd = i_wb_dat[7:0];
  wire [12:0] fl_addr = {addr_high_q, addr_low_q};
  wire ctl_wr = wr_acc & (i_wb_adr == `OFS_CONTROL);
  wire unl_wr = wr_acc & (i_wb_adr == `OFS_UNLOCK);
  wire busy = (state_q != ST_IDLE);

  // protected segment: 00 whole array, 01 lower half, 10 lower quarter, 11 none
  reg prot_hit;
  always @* begin
    case (flash_protect_q)
      2'h0: prot_hit = 1'b1;
      2'h1: prot_hit = ~fl_addr[12];
      2'h2: prot_hit = (fl_addr[12:11] == 2'h0);
      default: prot_hit = 1'b0;
    endcase
  end

  // [R3] [R4] accept start only when armed and enabled
  wire start_req = ctl_wr & wd[`BIT_WR] & ~write_start_q & ~busy;
  wire start_ok = start_req & (unlock_q == UL_ARMED) & write_enable_q;
  // [R12] [R19] words 01..11 must stay in the block that word 00 opened
  wire same_blk = (blk_q == 2'h0) | (fl_addr[12:2] == blk_base_q);
  // [R11] [R12] [R19] flash word must be in order and unprotected
  wire fl_ok = ~prot_hit & (addr_low_q[1:0] == blk_q) & same_blk;
  // a start in the same control write takes priority over a read
  wire rd_req = ctl_wr & wd[`BIT_RD] & ~read_start_q & ~busy & ~start_req;

  // [R9] [R17] stall during flash fetch, setup and block programming
  // combinational from state, so the stall drops the cycle the state leaves
  assign o_cpu_stall = (state_q == ST_FREAD) | (state_q == ST_SETUP) | (state_q == ST_PROG);
  assign o_write_done_flag = write_done_q;

  // [R23] consecutive unlock detector
  // reads leave it alone; only an intervening write breaks the sequence
  always @(posedge i_clk) begin
    if (i_rst) begin
      unlock_q <= UL_IDLE;
    end else if (wr_acc) begin
      if (unl_wr && wd == `UNLOCK_FIRST) begin
        unlock_q <= UL_GOT55;
      end else if (unl_wr && wd == `UNLOCK_SECOND && unlock_q == UL_GOT55) begin
        unlock_q <= UL_ARMED;
      end else begin
        unlock_q <= UL_IDLE;
      end
    end
  end

  // wishbone answer, one cycle after request
  // read data stands in the ack cycle only and is zero otherwise
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h0;
      if (rd_acc) begin
        case (i_wb_adr)
          `OFS_DATA_LOW: o_wb_dat <= {24'h0, data_low_q};
          `OFS_DATA_HIGH: o_wb_dat <= {26'h0, data_high_q};
          `OFS_ADDR_LOW: o_wb_dat <= {24'h0, addr_low_q};
          `OFS_ADDR_HIGH: o_wb_dat <= {27'h0, addr_high_q};
          `OFS_CONTROL: o_wb_dat <= {24'h0, memory_select_q, 3'h0, write_abort_q,
                                     write_enable_q, write_start_q, read_start_q};
          `OFS_STATUS: o_wb_dat <= {30'h0, o_cpu_stall, write_done_q};
          `OFS_PROTECT: o_wb_dat <= {30'h0, flash_protect_q};
          // [R22] unlock reads zero, unmapped too
          default: o_wb_dat <= 32'h0;
        endcase
      end
    end
  end

  // control, data and sequencing
  always @(posedge i_clk) begin
    if (i_rst) begin
      memory_select_q <= 1'b0;
      write_enable_q <= 1'b0;
      write_start_q <= 1'b0;
      read_start_q <= 1'b0;
      write_done_q <= 1'b0;
      flash_protect_q <= `PROTECT_RST;
      state_q <= ST_IDLE;
      cnt_q <= 32'h0;
      blk_q <= 2'h0;
      op_flash_q <= 1'b0;
      in_write_q <= 1'b0;
      blk_base_q <= 11'h0;
      // [R21] abort flag on reset mid-write; address and data untouched
      // the flag must survive a reset held for many cycles, since in_write_q
      // is already clear from the second reset edge on
      write_abort_q <= (in_write_q | write_abort_q) & i_abort_rst;
    end else begin
      if (wr_acc && i_wb_adr == `OFS_PROTECT) begin
        flash_protect_q <= wd[1:0];
      end
      // [R2] software writes the data registers
      if (wr_acc && i_wb_adr == `OFS_DATA_LOW) begin
        data_low_q <= wd;
      end
      if (wr_acc && i_wb_adr == `OFS_DATA_HIGH) begin
        data_high_q <= wd[5:0];
      end
      if (wr_acc && i_wb_adr == `OFS_ADDR_LOW) begin
        addr_low_q <= wd;
      end
      if (wr_acc && i_wb_adr == `OFS_ADDR_HIGH) begin
        addr_high_q <= wd[4:0];
      end
      if (ctl_wr) begin
        // [R5] enable only changes by software
        write_enable_q <= wd[`BIT_WRITE_ENABLE_BIT];
        write_abort_q <= wd[`BIT_WRITE_ABORT_FLAG];
        if (!busy && !write_start_q) begin
          memory_select_q <= wd[`BIT_MSEL];
        end
      end
      // done flag: set wins over software clear
      if (wr_acc && i_wb_adr == `OFS_STATUS && !wd[`BIT_DONE]) begin
        write_done_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          // [R20] start bits set only here, cleared by hardware
          if (start_ok && (!memory_select_q || fl_ok)) begin
            write_start_q <= 1'b1;
            in_write_q <= 1'b1;
            op_flash_q <= memory_select_q;
            if (memory_select_q) begin
              // [R13] latch word into block buffer
              buf_q[addr_low_q[1:0]] <= {data_high_q, data_low_q};
              if (blk_q == 2'h0) begin
                blk_base_q <= fl_addr[12:2];
              end
              cnt_q <= `FLASH_SETUP_CYC - 1;
              state_q <= ST_SETUP;
            end else begin
              cnt_q <= EE_WRITE_CYCLES - 1;
              state_q <= ST_EEWR;
            end
          end else if (rd_req && !memory_select_q) begin
            // [R1] eeprom byte ready next cycle
            data_low_q <= ee_mem[addr_low_q[EE_ABITS-1:0]];
          end else if (rd_req) begin
            read_start_q <= 1'b1;
            cnt_q <= 32'h1;
            state_q <= ST_FREAD;
          end
        end
        ST_FREAD: begin
          // [R9] [R10] two fetch cycles, then word to data registers
          if (cnt_q == 32'h0) begin
            data_low_q <= fl_mem[fl_addr[FL_ABITS-1:0]][7:0];
            data_high_q <= fl_mem[fl_addr[FL_ABITS-1:0]][13:8];
            read_start_q <= 1'b0;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        ST_SETUP: begin
          // [R16] two setup cycles
          if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
          end else if (blk_q == 2'h3) begin
            // [R14] [R17] last word: erase and program block
            cnt_q <= FLASH_PROG_CYCLES - 1;
            state_q <= ST_PROG;
          end else begin
            // [R17] buffer loads finish at once
            blk_q <= blk_q + 2'h1;
            write_start_q <= 1'b0;
            in_write_q <= 1'b0;
            write_done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_PROG, ST_EEWR: begin
          if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
          end else begin
            if (op_flash_q) begin
              // the whole block is rewritten in one edge, which also erases it
              // [R12] [R14] aligned block program
              fl_mem[{fl_addr[FL_ABITS-1:2], 2'h0}] <= buf_q[0];
              fl_mem[{fl_addr[FL_ABITS-1:2], 2'h1}] <= buf_q[1];
              fl_mem[{fl_addr[FL_ABITS-1:2], 2'h2}] <= buf_q[2];
              fl_mem[{fl_addr[FL_ABITS-1:2], 2'h3}] <= buf_q[3];
              blk_q <= 2'h0;
            end else begin
              // the byte committed is the one held in the data register now
              ee_mem[addr_low_q[EE_ABITS-1:0]] <= data_low_q;
            end
            // [R6] [R18] clear start, set done, release stall
            write_start_q <= 1'b0;
            in_write_q <= 1'b0;
            write_done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

// >>> hw/nvm_access_defines.vh
// nvm_access_defines.vh: register offsets, bit positions, reset values and timing
// assumes inclusion by the nonvolatile access controller, its assertions and its bench
`ifndef NVM_ACCESS_DEFINES_VH
`define NVM_ACCESS_DEFINES_VH

// register byte offsets on the wishbone slave
`define OFS_DATA_LOW 8'h00
`define OFS_ADDR_LOW 8'h04
`define OFS_DATA_HIGH 8'h08
`define OFS_ADDR_HIGH 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_UNLOCK 8'h14
`define OFS_STATUS 8'h18
`define OFS_PROTECT 8'h1C

// control register bits
`define BIT_RD 0
`define BIT_WR 1
`define BIT_WRITE_ENABLE_BIT 2
`define BIT_WRITE_ABORT_FLAG 3
`define BIT_MSEL 7
// status register bits
`define BIT_DONE 0
`define BIT_STALL 1

// unlock values
`define UNLOCK_FIRST 8'h55
`define UNLOCK_SECOND 8'hAA

// reset values
`define CONTROL_RST 8'h00
`define PROTECT_RST 2'h3

// timing
`define CLK_MHZ 125
`define FLASH_PROG_US 4000
`define FLASH_PROG_CYC (`FLASH_PROG_US * `CLK_MHZ)
`define EE_WRITE_US 4000
`define EE_WRITE_CYC (`EE_WRITE_US * `CLK_MHZ)
`define FLASH_SETUP_CYC 2

`endif
